// ### logic/ulsf_top.sv
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "ulsf_regs.svh"
module ulsf_top
   import ulsf_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic ce,
   input wire logic serial_rx_line,
   output logic serial_tx_line,
   output logic irq,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp
);
   logic rx_meta_ff, rx_s_ff, tx_line_ff, irq_ff;
   logic awready_ff, arready_ff, bvalid_ff, rvalid_ff;
   logic [1:0] bresp_ff, rresp_ff;
   logic [31:0] rdata_ff;
   logic [2:0] ctrl_ff, imask_ff, istat_ff, nxt_istat;
   logic [15:0] div_ff;
   ulsf_rx_ent_t fifo_mem [0:15];
   logic [3:0] wr_ptr_ff, rd_ptr_ff;
   logic [4:0] cnt_ff, err_cnt_ff, nxt_err_cnt;
   logic ovr_ff, parity_err_flag_ff, framing_err_flag_ff, break_flag_ff, rx_fifo_has_error_ff;
   logic [7:0] thr_ff;
   logic thr_full_ff;
   logic [9:0] tsr_ff;
   logic [3:0] tx_bits_ff;
   logic [15:0] tx_cnt_ff;
   ulsf_rx_st_t rx_st_ff, nxt_rx_st;
   logic [15:0] rx_cnt_ff, nxt_rx_cnt;
   logic [2:0] rx_bit_ff, nxt_rx_bit;
   logic [7:0] rx_sh_ff, nxt_rx_sh;
   logic rx_par_ff, nxt_rx_par, rx_zero_ff, nxt_rx_zero, rx_pbad_ff, nxt_rx_pbad;

   // ------------------------------------------------------------
   // pin synchroniser
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rx_meta_ff <= 1'b1;
         rx_s_ff <= 1'b1;
      end else if (ce) begin
         rx_meta_ff <= serial_rx_line;
         rx_s_ff <= rx_meta_ff;
      end
   end

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   // address and data are accepted together, so either arrival order works
   wire wr_go = s_axi_awvalid & s_axi_wvalid & ~awready_ff & ~bvalid_ff;
   wire wr_do = awready_ff;
   wire rd_go = s_axi_arvalid & ~arready_ff & ~rvalid_ff;
   wire rd_do = arready_ff;
   wire [7:0] wa = s_axi_awaddr;
   wire [7:0] ra = s_axi_araddr;
   wire wb0 = s_axi_wstrb[0];
   wire wr_thr = wr_do & wb0 & (wa == `ULSF_OFF_DATA);
   wire wr_ctrl = wr_do & wb0 & (wa == `ULSF_OFF_CTRL);
   wire wr_istat = wr_do & wb0 & (wa == `ULSF_OFF_ISTAT);
   wire wr_imask = wr_do & wb0 & (wa == `ULSF_OFF_IMASK);
   wire wr_div = wr_do & (wa == `ULSF_OFF_DIV);
   wire wr_hit = (wa == `ULSF_OFF_DATA) | (wa == `ULSF_OFF_CTRL) | (wa == `ULSF_OFF_DIV)
      | (wa == `ULSF_OFF_ISTAT) | (wa == `ULSF_OFF_IMASK);
   wire rd_hit = (ra == `ULSF_OFF_DATA) | (ra == `ULSF_OFF_CTRL) | (ra == `ULSF_OFF_DIV)
      | (ra == `ULSF_OFF_ISTAT) | (ra == `ULSF_OFF_IMASK) | (ra == `ULSF_OFF_LSR);
   wire rd_lsr = rd_do & (ra == `ULSF_OFF_LSR);
   wire fifo_en = ctrl_ff[`ULSF_CTRL_FIFO_EN];
   wire par_en = ctrl_ff[`ULSF_CTRL_PAR_EN];
   wire par_odd = ctrl_ff[`ULSF_CTRL_PAR_ODD];

   // ------------------------------------------------------------
   // receive fifo and head tracking
   // ------------------------------------------------------------
   wire rx_tick = (rx_cnt_ff == 16'h0000);
   wire rx_push = (rx_st_ff == RX_STOP) & rx_tick;
   ulsf_rx_ent_t rx_ent;
   assign rx_ent = '{brk: ~rx_s_ff & rx_zero_ff, frm_err: ~rx_s_ff,
      par_err: rx_pbad_ff, data: rx_sh_ff};
   // with the fifo off the buffer is a single holding slot
   wire [4:0] cap = fifo_en ? `ULSF_FIFO_DEPTH : `ULSF_ONE_DEEP;
   wire full = (cnt_ff >= cap);
   wire push = rx_push & ~full;
   wire ovr_ev = rx_push & full;
   ulsf_rx_ent_t head;
   assign head = fifo_mem[rd_ptr_ff];
   wire pop = rd_do & (ra == `ULSF_OFF_DATA) & (cnt_ff != 5'h00);
   wire ent_err = rx_ent.par_err | rx_ent.frm_err | rx_ent.brk;
   wire head_err = head.par_err | head.frm_err | head.brk;
   wire [4:0] cnt_rem = cnt_ff - {4'h0, pop};
   wire [3:0] nxt_hd = rd_ptr_ff + {3'h0, pop};
   // a new character reaches the head by pop or by push into an empty buffer
   wire new_head = (pop | (cnt_ff == 5'h00)) & ((cnt_rem != 5'h00) | push);
   ulsf_rx_ent_t nh_ent;
   assign nh_ent = (cnt_rem != 5'h00) ? fifo_mem[nxt_hd] : rx_ent;
   wire nh_err = nh_ent.par_err | nh_ent.frm_err | nh_ent.brk;
   assign nxt_err_cnt = err_cnt_ff + {4'h0, push & ent_err} - {4'h0, pop & head_err};

   always_ff @(posedge clock) begin
      if (ce && push) begin
         fifo_mem[wr_ptr_ff] <= rx_ent;
      end
   end

   // pointers and counters
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         wr_ptr_ff <= 4'h0;
         rd_ptr_ff <= 4'h0;
         cnt_ff <= 5'h00;
         err_cnt_ff <= 5'h00;
      end else if (ce) begin
         wr_ptr_ff <= wr_ptr_ff + {3'h0, push};
         rd_ptr_ff <= nxt_hd;
         cnt_ff <= cnt_rem + {4'h0, push};
         err_cnt_ff <= nxt_err_cnt;
      end
   end

   // ------------------------------------------------------------
   // line status flags
   // ------------------------------------------------------------
   // the read data is sampled at the same edge that clears, and a new
   // event wins over the clear, so nothing is lost across a read
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ovr_ff <= 1'b0;
         parity_err_flag_ff <= 1'b0;
         framing_err_flag_ff <= 1'b0;
         break_flag_ff <= 1'b0;
         rx_fifo_has_error_ff <= 1'b0;
      end else if (ce) begin
         ovr_ff <= ovr_ev | (ovr_ff & ~rd_lsr);
         parity_err_flag_ff <= (new_head & nh_ent.par_err)
            | (parity_err_flag_ff & ~rd_lsr);
         framing_err_flag_ff <= (new_head & nh_ent.frm_err)
            | (framing_err_flag_ff & ~rd_lsr);
         break_flag_ff <= (new_head & nh_ent.brk) | (break_flag_ff & ~rd_lsr);
         rx_fifo_has_error_ff <= fifo_en & ((push & ent_err)
            | (rx_fifo_has_error_ff & ~(rd_lsr & (nxt_err_cnt == 5'h00))));
      end
   end

   ulsf_lsr_t lsr;
   wire tx_busy = (tx_bits_ff != 4'h0);
   assign lsr = '{rx_fifo_has_error: rx_fifo_has_error_ff,
      tx_all_empty: ~thr_full_ff & ~tx_busy, tx_holding_empty: ~thr_full_ff,
      break_flag: break_flag_ff, framing_err_flag: framing_err_flag_ff, ovr: ovr_ff,
      parity_err_flag: parity_err_flag_ff, rx_data_ready: cnt_ff != 5'h00};

   // ------------------------------------------------------------
   // receiver
   // ------------------------------------------------------------
   always_comb begin
      nxt_rx_st = rx_st_ff;
      nxt_rx_cnt = rx_tick ? rx_cnt_ff : rx_cnt_ff - 16'h0001;
      nxt_rx_bit = rx_bit_ff;
      nxt_rx_sh = rx_sh_ff;
      nxt_rx_par = rx_par_ff;
      nxt_rx_zero = rx_zero_ff;
      nxt_rx_pbad = rx_pbad_ff;
      case (rx_st_ff)
         RX_IDLE: begin
            if (!rx_s_ff) begin
               nxt_rx_st = RX_START;
               nxt_rx_cnt = {1'b0, div_ff[15:1]};
            end
         end
         RX_START: begin
            if (rx_tick) begin
               // a high line mid-start is a glitch, not a character
               nxt_rx_st = rx_s_ff ? RX_IDLE : RX_DATA;
               nxt_rx_cnt = div_ff - 16'h0001;
               nxt_rx_bit = 3'h0;
               nxt_rx_par = 1'b0;
               nxt_rx_zero = 1'b1;
               nxt_rx_pbad = 1'b0;
            end
         end
         RX_DATA: begin
            if (rx_tick) begin
               nxt_rx_sh = {rx_s_ff, rx_sh_ff[7:1]};
               nxt_rx_par = rx_par_ff ^ rx_s_ff;
               nxt_rx_zero = rx_zero_ff & ~rx_s_ff;
               nxt_rx_bit = rx_bit_ff + 3'h1;
               nxt_rx_cnt = div_ff - 16'h0001;
               if (rx_bit_ff == `ULSF_LAST_DATA) begin
                  nxt_rx_st = par_en ? RX_PAR : RX_STOP;
               end
            end
         end
         RX_PAR: begin
            if (rx_tick) begin
               nxt_rx_pbad = rx_par_ff ^ rx_s_ff ^ par_odd;
               nxt_rx_zero = rx_zero_ff & ~rx_s_ff;
               nxt_rx_cnt = div_ff - 16'h0001;
               nxt_rx_st = RX_STOP;
            end
         end
         RX_STOP: begin
            if (rx_tick) begin
               nxt_rx_cnt = div_ff - 16'h0001;
               nxt_rx_bit = 3'h0;
               nxt_rx_par = 1'b0;
               nxt_rx_zero = 1'b1;
               nxt_rx_pbad = 1'b0;
               if (rx_s_ff) begin
                  nxt_rx_st = RX_IDLE;
               end else if (rx_zero_ff) begin
                  nxt_rx_st = RX_BREAK;
               end else begin
                  nxt_rx_st = RX_DATA;
               end
            end
         end
         RX_BREAK: begin
            if (rx_s_ff) begin
               nxt_rx_st = RX_IDLE;
            end
         end
         default: nxt_rx_st = RX_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rx_st_ff <= RX_IDLE;
         rx_cnt_ff <= 16'h0000;
         rx_bit_ff <= 3'h0;
         rx_sh_ff <= 8'h00;
         rx_par_ff <= 1'b0;
         rx_zero_ff <= 1'b1;
         rx_pbad_ff <= 1'b0;
      end else if (ce) begin
         rx_st_ff <= nxt_rx_st;
         rx_cnt_ff <= nxt_rx_cnt;
         rx_bit_ff <= nxt_rx_bit;
         rx_sh_ff <= nxt_rx_sh;
         rx_par_ff <= nxt_rx_par;
         rx_zero_ff <= nxt_rx_zero;
         rx_pbad_ff <= nxt_rx_pbad;
      end
   end

   // ------------------------------------------------------------
   // transmitter
   // ------------------------------------------------------------
   wire tx_load = thr_full_ff & ~tx_busy;
   wire tx_tick = tx_busy & (tx_cnt_ff == 16'h0000);
   wire tx_par = (^thr_ff) ^ par_odd;
   // a write that meets a load keeps the new byte; holding only one byte
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         thr_ff <= 8'h00;
         thr_full_ff <= 1'b0;
         tsr_ff <= 10'h3ff;
         tx_bits_ff <= 4'h0;
         tx_cnt_ff <= 16'h0000;
         tx_line_ff <= 1'b1;
      end else if (ce) begin
         thr_full_ff <= wr_thr | (thr_full_ff & ~tx_load);
         if (wr_thr) begin
            thr_ff <= s_axi_wdata[7:0];
         end
         if (tx_load) begin
            tx_line_ff <= 1'b0;
            tsr_ff <= {1'b1, par_en ? tx_par : 1'b1, thr_ff};
            tx_bits_ff <= par_en ? `ULSF_TX_BITS_PAR : `ULSF_TX_BITS_NOPAR;
            tx_cnt_ff <= div_ff - 16'h0001;
         end else if (tx_tick) begin
            tx_line_ff <= (tx_bits_ff == 4'h1) ? 1'b1 : tsr_ff[0];
            tsr_ff <= {1'b1, tsr_ff[9:1]};
            tx_bits_ff <= tx_bits_ff - 4'h1;
            tx_cnt_ff <= div_ff - 16'h0001;
         end else if (tx_busy) begin
            tx_cnt_ff <= tx_cnt_ff - 16'h0001;
         end
      end
   end

   // ------------------------------------------------------------
   // control, interrupts and bus answers
   // ------------------------------------------------------------
   wire [2:0] int_ev;
   assign int_ev[`ULSF_INT_RX] = push;
   assign int_ev[`ULSF_INT_LINE] = ovr_ev | (new_head & nh_err);
   assign int_ev[`ULSF_INT_TX_HOLDING_EMPTY] = tx_load;
   // set beats a same-cycle write-one clear
   assign nxt_istat = int_ev | (istat_ff & ~(wr_istat ? s_axi_wdata[2:0] : 3'h0));
   wire [31:0] rd_val =
      (ra == `ULSF_OFF_DATA) ? {24'h0, (cnt_ff != 5'h00) ? head.data : 8'h00} :
      (ra == `ULSF_OFF_CTRL) ? {29'h0, ctrl_ff} :
      (ra == `ULSF_OFF_DIV) ? {16'h0, div_ff} :
      (ra == `ULSF_OFF_LSR) ? {24'h0, lsr} :
      (ra == `ULSF_OFF_ISTAT) ? {29'h0, istat_ff} :
      (ra == `ULSF_OFF_IMASK) ? {29'h0, imask_ff} : 32'h0;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ctrl_ff <= `ULSF_CTRL_RST;
         div_ff <= `ULSF_DIV_RST;
         imask_ff <= 3'h0;
         istat_ff <= 3'h0;
         irq_ff <= 1'b0;
      end else if (ce) begin
         if (wr_ctrl) ctrl_ff <= s_axi_wdata[2:0];
         if (wr_div) div_ff <= s_axi_wdata[15:0];
         if (wr_imask) imask_ff <= s_axi_wdata[2:0];
         istat_ff <= nxt_istat;
         irq_ff <= |(nxt_istat & imask_ff);
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         awready_ff <= 1'b0;
         arready_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         rvalid_ff <= 1'b0;
         bresp_ff <= `ULSF_RESP_OK;
         rresp_ff <= `ULSF_RESP_OK;
         rdata_ff <= 32'h0;
      end else if (ce) begin
         awready_ff <= wr_go;
         arready_ff <= rd_go;
         if (wr_do) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_hit ? `ULSF_RESP_OK : `ULSF_RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
         end
         if (rd_do) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_val;
            rresp_ff <= rd_hit ? `ULSF_RESP_OK : `ULSF_RESP_SLVERR;
         end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
         end
      end
   end

   assign s_axi_awready = awready_ff;
   assign s_axi_wready = awready_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;
   assign serial_tx_line = tx_line_ff;
   assign irq = irq_ff;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   property p_data_ready; ce && push |=> lsr.rx_data_ready; endproperty
   a_data_ready: assert property (p_data_ready) else $error("data ready not set after push");
   property p_ovr; ce && rx_push && full |=> ovr_ff && $stable(wr_ptr_ff); endproperty
   a_ovr: assert property (p_ovr) else $error("overrun wrong");
   property p_ovr_hold; ce && ovr_ff && !rd_lsr |=> ovr_ff; endproperty
   a_ovr_hold: assert property (p_ovr_hold) else $error("overrun lost");
   property p_par_clr; ce && rd_lsr && !new_head |=> !parity_err_flag_ff; endproperty
   a_par_clr: assert property (p_par_clr) else $error("parity flag not cleared");
   property p_resync; ce && rx_push && !rx_s_ff && !rx_zero_ff |=> rx_st_ff == RX_DATA;
   endproperty
   a_resync: assert property (p_resync) else $error("no resync on bad stop");
   property p_brk; ce && rx_st_ff == RX_BREAK && !rx_s_ff |=> rx_st_ff == RX_BREAK;
   endproperty
   a_brk: assert property (p_brk) else $error("left break on low line");
   property p_hold_empty; ce && wr_thr |=> !lsr.tx_holding_empty ##0 !lsr.tx_all_empty;
   endproperty
   a_hold_empty: assert property (p_hold_empty) else $error("holding empty after write");
   property p_fifo_err_off; ce && !fifo_en |=> !rx_fifo_has_error_ff; endproperty
   a_fifo_err_off: assert property (p_fifo_err_off) else $error("fifo error with fifo off");
endmodule

// ### logic/ulsf_regs.svh
`ifndef ULSF_REGS_SVH
`define ULSF_REGS_SVH
// register byte offsets
`define ULSF_OFF_DATA 8'h00
`define ULSF_OFF_CTRL 8'h04
`define ULSF_OFF_DIV 8'h08
`define ULSF_OFF_LSR 8'h14
`define ULSF_OFF_ISTAT 8'h18
`define ULSF_OFF_IMASK 8'h1c
// control fields
`define ULSF_CTRL_FIFO_EN 0
`define ULSF_CTRL_PAR_EN 1
`define ULSF_CTRL_PAR_ODD 2
`define ULSF_CTRL_RST 3'h0
// interrupt status / mask fields
`define ULSF_INT_RX 0
`define ULSF_INT_LINE 1
`define ULSF_INT_TX_HOLDING_EMPTY 2
// cycles per bit, default near 115200 baud at 40 MHz
`define ULSF_DIV_RST 16'h015b
`define ULSF_FIFO_DEPTH 5'h10
`define ULSF_ONE_DEEP 5'h01
`define ULSF_TX_BITS_PAR 4'hb
`define ULSF_TX_BITS_NOPAR 4'ha
`define ULSF_LAST_DATA 3'h7
`define ULSF_RESP_OK 2'h0
`define ULSF_RESP_SLVERR 2'h2
`endif

// ### logic/ulsf_pkg.sv
package ulsf_pkg;
   // one receive fifo entry: the character and its own error marks
   typedef struct packed {
      logic brk;
      logic frm_err;
      logic par_err;
      logic [7:0] data;
   } ulsf_rx_ent_t;
   // line status as read by software, msb first
   typedef struct packed {
      logic rx_fifo_has_error;
      logic tx_all_empty;
      logic tx_holding_empty;
      logic break_flag;
      logic framing_err_flag;
      logic parity_err_flag;
      logic ovr;
      logic rx_data_ready;
   } ulsf_lsr_t;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BREAK} ulsf_rx_st_t;
endpackage

// ### dv/ulsf_remote_uart.sv
`timescale 1ns/100ps
// ------------------------------------------
// remote serial end: frame sender and receiver
// ------------------------------------------
module ulsf_remote_uart
#(parameter int BIT_CYC = 16)
(
   input wire logic clock,
   output logic line_out,
   input wire logic line_in
);
   logic [7:0] got[$];
   logic [7:0] sh;
   // marking level from time zero, so no false start at reset release
   initial begin
      line_out = 1'b1;
   end
   // one bit time, changed just after an edge
   task automatic bit_out(input logic b);
      line_out <= b;
      repeat (BIT_CYC) @(posedge clock);
   endtask
   // st low sends no start bit: continues straight after a bad stop bit
   task automatic send(input logic [7:0] d, input logic st, input logic p_en,
      input logic p_odd, input logic p_bad, input logic stop);
      if (st) begin
         bit_out(1'b0);
      end
      for (int i = 0; i < 8; i++) begin
         bit_out(d[i]);
      end
      if (p_en) begin
         bit_out(^d ^ p_odd ^ p_bad);
      end
      bit_out(stop);
   endtask
   // spacing level for n bit times, then back to marking
   task automatic hold_low(input int n);
      line_out <= 1'b0;
      repeat (n * BIT_CYC) @(posedge clock);
      line_out <= 1'b1;
   endtask
   // receiver samples mid-bit; keeps every character it sees
   always begin
      @(negedge line_in);
      repeat (BIT_CYC / 2) @(posedge clock);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CYC) @(posedge clock);
         sh[i] = line_in;
      end
      repeat (BIT_CYC) @(posedge clock);
      got.push_back(sh);
   end
endmodule

// ### dv/uart_line_status_flags_tb.sv
`timescale 1ns/100ps
`include "ulsf_regs.svh"
module uart_line_status_flags_tb
   import ulsf_pkg::*;
;
   localparam int BIT = 16;
   logic clock, nrst, ce, serial_rx_line, serial_tx_line, irq;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   int err_count = 0;
   int compares = 0;
   int cyc = 0;
   int dep;

   ulsf_top dut_u (.clock, .nrst, .ce, .serial_rx_line, .serial_tx_line, .irq,
      .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
      .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
      .s_axi_rdata, .s_axi_rresp);
   ulsf_remote_uart #(.BIT_CYC(BIT)) rem_u (.clock, .line_out(serial_rx_line),
      .line_in(serial_tx_line));

   // ------------------------------------------
   // clock, hang guard and bus tasks
   // ------------------------------------------
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   // whole run needs well under ten thousand cycles
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         print_verdict();
      end
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // each channel released when taken; extra edge keeps ready from being set twice
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clock);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge clock);
   endtask
   task automatic rd(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clock);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rdat = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge clock);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk($sformatf("reg %h", a), rdat, e);
   endtask
   task automatic irq_chk(input logic e);
      repeat (2) @(posedge clock);
      #1;
      chk("irq", 32'(irq), 32'(e));
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ------------------------------------------
   // main sequence
   // ------------------------------------------
   initial begin
      nrst = 1'b0;
      ce = 1'b1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      repeat (12) @(posedge clock);
      nrst <= 1'b1;
      @(posedge clock);
      rchk(`ULSF_OFF_LSR, 32'h60);
      rchk(`ULSF_OFF_DIV, 32'h15b);
      rchk(`ULSF_OFF_CTRL, 32'h0);
      rchk(`ULSF_OFF_IMASK, 32'h0);
      rd(8'h40);
      chk("unmapped read resp", {30'h0, resp}, 32'(`ULSF_RESP_SLVERR));
      wr(8'h40, 32'h1);
      chk("unmapped write resp", {30'h0, resp}, 32'(`ULSF_RESP_SLVERR));
      wr(`ULSF_OFF_DIV, 32'(BIT));
      // one-deep buffer, then the deep fifo, each filled one past full
      for (int m = 0; m < 2; m++) begin
         dep = (m == 1) ? 16 : 1;
         wr(`ULSF_OFF_CTRL, 32'(m));
         for (int i = 0; i <= dep; i++) begin
            rem_u.send(8'(i + 48), 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
         end
         rchk(`ULSF_OFF_LSR, 32'h63);
         for (int i = 0; i < dep; i++) begin
            rchk(`ULSF_OFF_DATA, 32'(i + 48));
         end
         rchk(`ULSF_OFF_LSR, 32'h60);
      end
      // odd parity good, then bad, buffer off
      wr(`ULSF_OFF_CTRL, 32'h6);
      rem_u.send(8'h5a, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
      rchk(`ULSF_OFF_LSR, 32'h61);
      rchk(`ULSF_OFF_DATA, 32'h5a);
      rem_u.send(8'h5b, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
      rchk(`ULSF_OFF_LSR, 32'h65);
      rchk(`ULSF_OFF_LSR, 32'h61);
      rchk(`ULSF_OFF_DATA, 32'h5b);
      // even parity, fifo on: error must wait until its character is head
      wr(`ULSF_OFF_CTRL, 32'h3);
      rem_u.send(8'h11, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
      rem_u.send(8'h22, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
      rchk(`ULSF_OFF_LSR, 32'he1);
      rchk(`ULSF_OFF_LSR, 32'he1);
      rchk(`ULSF_OFF_DATA, 32'h11);
      rchk(`ULSF_OFF_LSR, 32'he5);
      rchk(`ULSF_OFF_LSR, 32'he1);
      rchk(`ULSF_OFF_DATA, 32'h22);
      rd(`ULSF_OFF_LSR);
      rchk(`ULSF_OFF_LSR, 32'h60);
      // bad stop bit runs straight into the next character's data
      wr(`ULSF_OFF_CTRL, 32'h1);
      rem_u.send(8'h81, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      rem_u.send(8'h3c, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
      rchk(`ULSF_OFF_LSR, 32'he9);
      rchk(`ULSF_OFF_DATA, 32'h81);
      rchk(`ULSF_OFF_DATA, 32'h3c);
      rd(`ULSF_OFF_LSR);
      rchk(`ULSF_OFF_LSR, 32'h60);
      // long spacing: one break character only
      rem_u.hold_low(30);
      repeat (2 * BIT) @(posedge clock);
      rchk(`ULSF_OFF_LSR, 32'hf9);
      rchk(`ULSF_OFF_DATA, 32'h0);
      rd(`ULSF_OFF_LSR);
      rchk(`ULSF_OFF_LSR, 32'h60);
      // transmit: holding and shift both loaded, then both drained
      wr(`ULSF_OFF_CTRL, 32'h0);
      wr(`ULSF_OFF_DATA, 32'ha5);
      rd(`ULSF_OFF_LSR);
      chk("tx all empty", rdat & 32'h40, 32'h0);
      wr(`ULSF_OFF_DATA, 32'h3c);
      rchk(`ULSF_OFF_LSR, 32'h00);
      repeat (30 * BIT) @(posedge clock);
      rchk(`ULSF_OFF_LSR, 32'h60);
      chk("tx count", 32'(rem_u.got.size()), 32'h2);
      chk("tx first", {24'h0, rem_u.got[0]}, 32'ha5);
      chk("tx second", {24'h0, rem_u.got[1]}, 32'h3c);
      // interrupt: masked, strobe-less mask write ignored, unmasked, cleared
      wr(`ULSF_OFF_ISTAT, 32'h7);
      rem_u.send(8'h77, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
      irq_chk(1'b0);
      rchk(`ULSF_OFF_ISTAT, 32'h1);
      s_axi_wstrb <= 4'he;
      wr(`ULSF_OFF_IMASK, 32'h1);
      s_axi_wstrb <= 4'hf;
      rchk(`ULSF_OFF_IMASK, 32'h0);
      wr(`ULSF_OFF_IMASK, 32'h1);
      irq_chk(1'b1);
      wr(`ULSF_OFF_ISTAT, 32'h1);
      irq_chk(1'b0);
      rchk(`ULSF_OFF_DATA, 32'h77);
      rchk(`ULSF_OFF_LSR, 32'h60);
      // enable low freezes the bus too: a read must wait out the frozen cycles
      ce <= 1'b0;
      fork
         begin
            repeat (8) @(posedge clock);
            ce <= 1'b1;
         end
      join_none
      dep = cyc;
      rchk(`ULSF_OFF_LSR, 32'h60);
      chk("ce freeze", 32'(cyc - dep > 8), 32'h1);
      print_verdict();
   end
endmodule
